// >>> hdl/sar_status_regs.vh
// Constants for the status and ADC error register bank.
// Assumes inclusion by bare name from every design file of the bank.
// What this block does
// - Top field of general status carries the 4-bit clock ratio reading; 1000 +/-1 means reference present.
// - Bits 7..5 hold the reset cause caught on the latest pass through off.
// - Cause codes: 000 power-on, 001 projector low, 010/011 watchdogs, 100 heat, 101 software.
// - Bits 4..0 show the current top state; register is read-only, resets zero.
// - Power-up codes 0x00 to 0x08: shutdown, init, off, rails, reset release, standby.
// - Display path codes 0x09, 0x0A, 0x0C, 0x0D; 0x0B is not assigned.
// - Parking codes 0x0E to 0x11, ending in mirror voltage discharge.
// - ADC error register resets zero; writing one to a bit sets that flag.
// - One summary bit carries the OR of all ADC error flags.
// - Bit 7 sets on a link command missing its stop bit.
// - Bit 6 sets on a new command while one still runs.
// - Bit 5 sets on a malformed command on the ADC command link.
// - Bit 4 sets on a parity failure in the command bit stream.
// - Bit 2 sets on second channel saturation, bit 0 on first channel.
// - Bit 3 sets on second channel underflow, bit 1 on first channel.
// - Summary is bit 11 of main status; cause is read from ADC register.
// - Projector-on pin low requests power down and is its own reset cause.
`ifndef SAR_STATUS_REGS_VH
`define SAR_STATUS_REGS_VH

// Register offsets
`define SAR_ADDR_W               7
`define SAR_ADDR_GEN_STATUS      7'h05
`define SAR_ADDR_ADC_FLAGS       7'h0d
`define SAR_DATA_W               16
`define SAR_RESET_VALUE          16'h0000
`define SAR_MAIN_ADC_SUM_BIT     11

// General status field layout
`define SAR_RATIO_MSB            15
`define SAR_RATIO_LSB            12
`define SAR_RSVD_MSB             11
`define SAR_RSVD_LSB             8
`define SAR_CAUSE_MSB            7
`define SAR_CAUSE_LSB            5
`define SAR_STATE_MSB            4
`define SAR_STATE_LSB            0
`define SAR_RATIO_W              4
`define SAR_RSVD_W               4
`define SAR_CAUSE_W              3
`define SAR_STATE_W              5

// Clock ratio window around mid-scale
`define SAR_RATIO_MID_LO         4'h7
`define SAR_RATIO_MID_HI         4'h9

// ADC error flag layout
`define SAR_FLAG_W               8
`define SAR_FLAG_UNUSED_W        8
`define SAR_FLAG_STOP_BIT        7
`define SAR_FLAG_OVERLAP         6
`define SAR_FLAG_CMD             5
`define SAR_FLAG_PARITY          4
`define SAR_FLAG_CH2_UNDER       3
`define SAR_FLAG_CH2_SAT         2
`define SAR_FLAG_CH1_UNDER       1
`define SAR_FLAG_CH1_SAT         0

// Reset cause codes
`define SAR_CAUSE_POWER_ON       3'h0
`define SAR_CAUSE_PROJ_LOW       3'h1
`define SAR_CAUSE_WDOG1          3'h2
`define SAR_CAUSE_WDOG2          3'h3
`define SAR_CAUSE_OVER_TEMP      3'h4
`define SAR_CAUSE_SW_CYCLE       3'h5

// Top state codes
`define SAR_ST_SHUTDOWN          5'h00
`define SAR_ST_INIT_A            5'h01
`define SAR_ST_OFF               5'h02
`define SAR_ST_INIT_B            5'h03
`define SAR_ST_RAIL_1P1          5'h04
`define SAR_ST_RAIL_1P8          5'h05
`define SAR_ST_RAIL_3P3          5'h06
`define SAR_ST_RESET_RELEASE     5'h07
`define SAR_ST_STANDBY           5'h08
`define SAR_ST_OFFSET_ON         5'h09
`define SAR_ST_BIAS_ON           5'h0a
`define SAR_ST_DISPLAY_RDY       5'h0c
`define SAR_ST_DISPLAY_ON        5'h0d
`define SAR_ST_PARK_START        5'h0e
`define SAR_ST_BIAS_RST_OFF      5'h0f
`define SAR_ST_OFFSET_OFF        5'h10
`define SAR_ST_DISCHARGE         5'h11

`endif

// >>> hdl/sar_sticky_flags.v
// Sticky flag bank: hardware and write-one sets, cleared only by reset.
// Assumes set inputs are single-clock-domain and synchronous to i_clk_sys.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module sar_sticky_flags #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         i_clk_sys,
   input  wire         i_arst_n,
   input  wire         i_clk_en,
   // Set sources
   input  wire [W-1:0] i_hw_set,
   input  wire [W-1:0] i_sw_set,
   // Flag state
   output wire [W-1:0] o_flags
);

   reg  [W-1:0] flags_r;
   wire [W-1:0] flags_nxt;

   assign flags_nxt = flags_r | i_hw_set | i_sw_set;

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flags_r <= {W{1'b0}};
      end else if (i_clk_en) begin
         flags_r <= flags_nxt;
      end
   end

   assign o_flags = flags_r;

endmodule

// >>> hdl/sar_reset_cause.v
// Reset cause recorder: gathers power-down causes, commits one on entry to off.
// Assumes the top state is already sampled into the system clock domain.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module sar_reset_cause (
   // Clock and reset
   input  wire                    i_clk_sys,
   input  wire                    i_arst_n,
   input  wire                    i_clk_en,
   // Cause events
   input  wire                    i_proj_low,
   input  wire                    i_wdog1_err,
   input  wire                    i_wdog2_err,
   input  wire                    i_over_temp,
   input  wire                    i_sw_cycle,
   // Off state entry
   input  wire                    i_off_entry,
   // Committed cause
   output wire [`SAR_CAUSE_W-1:0] o_cause
);

   reg  [`SAR_CAUSE_W-1:0] pend_r;
   reg  [`SAR_CAUSE_W-1:0] cause_r;
   reg  [`SAR_CAUSE_W-1:0] evt_code;
   reg                     evt_any;

   // Most severe cause wins when several arrive together
   always @* begin
      evt_any  = 1'b1;
      evt_code = `SAR_CAUSE_POWER_ON;
      if (i_over_temp) begin
         evt_code = `SAR_CAUSE_OVER_TEMP;
      end else if (i_sw_cycle) begin
         evt_code = `SAR_CAUSE_SW_CYCLE;
      end else if (i_wdog2_err) begin
         evt_code = `SAR_CAUSE_WDOG2;
      end else if (i_wdog1_err) begin
         evt_code = `SAR_CAUSE_WDOG1;
      end else if (i_proj_low) begin
         evt_code = `SAR_CAUSE_PROJ_LOW;
      end else begin
         evt_any  = 1'b0;
      end
   end

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pend_r  <= `SAR_CAUSE_POWER_ON;
         cause_r <= `SAR_CAUSE_POWER_ON;
      end else if (i_clk_en) begin
         // A new event beats the clear that follows a commit
         if (evt_any && (i_off_entry || (pend_r == `SAR_CAUSE_POWER_ON))) begin
            pend_r <= evt_code;
         end else if (i_off_entry) begin
            pend_r <= `SAR_CAUSE_POWER_ON;
         end
         if (i_off_entry) begin
            cause_r <= pend_r;
         end
      end
   end

   assign o_cause = cause_r;

endmodule

// >>> hdl/sar_status_top.v
// Status register bank: general status and sticky ADC error flags with summary.
// Assumes all inputs synchronous to i_clk_sys; the register port is driven by
// the serial control port logic, one access per strobe.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module sar_status_top (
   // Clock, reset, enable
   input  wire                    i_clk_sys,
   input  wire                    i_arst_n,
   input  wire                    i_clk_en,
   // Register port
   input  wire [`SAR_ADDR_W-1:0]  i_reg_addr,
   input  wire                    i_reg_wr,
   input  wire                    i_reg_rd,
   input  wire [`SAR_DATA_W-1:0]  i_reg_wdata,
   output wire [`SAR_DATA_W-1:0]  o_reg_rdata,
   output wire                    o_reg_rvalid,
   output wire                    o_reg_hit,
   // Monitors and state machine
   input  wire [`SAR_RATIO_W-1:0] i_clk_ratio,
   input  wire [`SAR_STATE_W-1:0] i_top_state,
   input  wire                    i_projector_on_input,
   input  wire                    i_wdog1_err,
   input  wire                    i_wdog2_err,
   input  wire                    i_over_temp,
   input  wire                    i_sw_cycle,
   // ADC command link and channel events
   input  wire                    i_adc_stop_bit_err,
   input  wire                    i_adc_overlap_err,
   input  wire                    i_adc_cmd_err,
   input  wire                    i_adc_parity_err,
   input  wire                    i_second_channel_underflow,
   input  wire                    i_second_channel_sat,
   input  wire                    i_first_channel_underflow,
   input  wire                    i_first_channel_sat,
   // Status outputs
   output wire                    o_adc_error_summary,
   output wire                    o_ref_clk_present,
   output wire                    o_power_down_req,
   output wire [`SAR_CAUSE_W-1:0] o_reset_cause,
   output wire [`SAR_STATE_W-1:0] o_top_state,
   // State phase outputs
   output wire                    o_phase_powerup,
   output wire                    o_phase_display,
   output wire                    o_phase_parking,
   output wire                    o_state_unknown,
   output wire                    o_mirror_offset_rail_up,
   output wire                    o_mirror_bias_rail_up
);

   localparam PH_POWERUP = 4'b0001;
   localparam PH_DISPLAY = 4'b0010;
   localparam PH_PARKING = 4'b0100;
   localparam PH_UNKNOWN = 4'b1000;

   // Sampled inputs
   reg  [`SAR_RATIO_W-1:0]  ratio_r;
   reg  [`SAR_STATE_W-1:0]  state_r;
   reg  [`SAR_STATE_W-1:0]  state_prev_r;
   reg                      proj_low_r;

   // Read path
   reg  [`SAR_DATA_W-1:0]   rdata_r;
   reg  [`SAR_DATA_W-1:0]   rdata_nxt;
   reg                      rvalid_r;
   reg                      hit_nxt;

   // Derived status
   reg                      adc_sum_r;
   reg                      ref_ok_r;
   reg  [3:0]               phase_r;
   reg  [3:0]               phase_nxt;
   reg                      offset_up_r;
   reg                      offset_up_nxt;
   reg                      bias_up_r;
   reg                      bias_up_nxt;

   wire [`SAR_FLAG_W-1:0]   hw_set;
   wire [`SAR_FLAG_W-1:0]   sw_set;
   wire [`SAR_FLAG_W-1:0]   flags;
   wire [`SAR_CAUSE_W-1:0]  cause;
   wire [`SAR_DATA_W-1:0]   gen_status;
   wire [`SAR_DATA_W-1:0]   adc_status;
   wire                     off_entry;
   wire                     wr_flags;

   // Sample monitor inputs into flip-flops
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ratio_r      <= {`SAR_RATIO_W{1'b0}};
         state_r      <= `SAR_ST_SHUTDOWN;
         state_prev_r <= `SAR_ST_SHUTDOWN;
         proj_low_r   <= 1'b0;
      end else if (i_clk_en) begin
         ratio_r      <= i_clk_ratio;
         state_r      <= i_top_state;
         state_prev_r <= state_r;
         proj_low_r   <= ~i_projector_on_input;
      end
   end

   assign off_entry = (state_r == `SAR_ST_OFF) && (state_prev_r != `SAR_ST_OFF);

   // ADC error flag sources
   assign hw_set[`SAR_FLAG_STOP_BIT]  = i_adc_stop_bit_err;
   assign hw_set[`SAR_FLAG_OVERLAP]   = i_adc_overlap_err;
   assign hw_set[`SAR_FLAG_CMD]       = i_adc_cmd_err;
   assign hw_set[`SAR_FLAG_PARITY]    = i_adc_parity_err;
   assign hw_set[`SAR_FLAG_CH2_UNDER] = i_second_channel_underflow;
   assign hw_set[`SAR_FLAG_CH2_SAT]   = i_second_channel_sat;
   assign hw_set[`SAR_FLAG_CH1_UNDER] = i_first_channel_underflow;
   assign hw_set[`SAR_FLAG_CH1_SAT]   = i_first_channel_sat;

   // Write-one-to-set; upper unused bits are dropped
   assign wr_flags = i_reg_wr && (i_reg_addr == `SAR_ADDR_ADC_FLAGS);
   assign sw_set   = wr_flags ? i_reg_wdata[`SAR_FLAG_W-1:0] : {`SAR_FLAG_W{1'b0}};

   sar_sticky_flags #(
      .W (`SAR_FLAG_W)
   ) u_flags (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_clk_en  (i_clk_en),
      .i_hw_set  (hw_set),
      .i_sw_set  (sw_set),
      .o_flags   (flags)
   );

   sar_reset_cause u_cause (
      .i_clk_sys   (i_clk_sys),
      .i_arst_n    (i_arst_n),
      .i_clk_en    (i_clk_en),
      .i_proj_low  (proj_low_r),
      .i_wdog1_err (i_wdog1_err),
      .i_wdog2_err (i_wdog2_err),
      .i_over_temp (i_over_temp),
      .i_sw_cycle  (i_sw_cycle),
      .i_off_entry (off_entry),
      .o_cause     (cause)
   );

   // Register images
   assign gen_status = {ratio_r,
                        {`SAR_RSVD_W{1'b0}},
                        cause,
                        state_r};
   assign adc_status = {{`SAR_FLAG_UNUSED_W{1'b0}}, flags};

   // Read multiplexer; unmapped offsets read zero
   always @* begin
      rdata_nxt = `SAR_RESET_VALUE;
      hit_nxt   = 1'b0;
      case (i_reg_addr)
         `SAR_ADDR_GEN_STATUS: begin
            rdata_nxt = gen_status;
            hit_nxt   = 1'b1;
         end
         `SAR_ADDR_ADC_FLAGS: begin
            rdata_nxt = adc_status;
            hit_nxt   = 1'b1;
         end
         default: begin
            rdata_nxt = `SAR_RESET_VALUE;
            hit_nxt   = 1'b0;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r  <= `SAR_RESET_VALUE;
         rvalid_r <= 1'b0;
      end else if (i_clk_en) begin
         rvalid_r <= i_reg_rd;
         if (i_reg_rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // Phase decode of the top state
   always @* begin
      phase_nxt     = PH_UNKNOWN;
      offset_up_nxt = 1'b0;
      bias_up_nxt   = 1'b0;
      case (state_r)
         `SAR_ST_SHUTDOWN,
         `SAR_ST_INIT_A,
         `SAR_ST_OFF,
         `SAR_ST_INIT_B,
         `SAR_ST_RAIL_1P1,
         `SAR_ST_RAIL_1P8,
         `SAR_ST_RAIL_3P3,
         `SAR_ST_RESET_RELEASE,
         `SAR_ST_STANDBY: begin
            phase_nxt = PH_POWERUP;
         end
         `SAR_ST_OFFSET_ON: begin
            phase_nxt     = PH_DISPLAY;
            offset_up_nxt = 1'b1;
         end
         `SAR_ST_BIAS_ON,
         `SAR_ST_DISPLAY_RDY,
         `SAR_ST_DISPLAY_ON: begin
            phase_nxt     = PH_DISPLAY;
            offset_up_nxt = 1'b1;
            bias_up_nxt   = 1'b1;
         end
         `SAR_ST_PARK_START: begin
            phase_nxt     = PH_PARKING;
            offset_up_nxt = 1'b1;
            bias_up_nxt   = 1'b1;
         end
         `SAR_ST_BIAS_RST_OFF: begin
            phase_nxt     = PH_PARKING;
            offset_up_nxt = 1'b1;
         end
         `SAR_ST_OFFSET_OFF,
         `SAR_ST_DISCHARGE: begin
            phase_nxt = PH_PARKING;
         end
         default: begin
            phase_nxt = PH_UNKNOWN;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_r     <= PH_POWERUP;
         offset_up_r <= 1'b0;
         bias_up_r   <= 1'b0;
         adc_sum_r   <= 1'b0;
         ref_ok_r    <= 1'b0;
      end else if (i_clk_en) begin
         phase_r     <= phase_nxt;
         offset_up_r <= offset_up_nxt;
         bias_up_r   <= bias_up_nxt;
         adc_sum_r   <= |flags;
         ref_ok_r    <= (ratio_r >= `SAR_RATIO_MID_LO) && (ratio_r <= `SAR_RATIO_MID_HI);
      end
   end

   // Outputs
   assign o_reg_rdata             = rdata_r;
   assign o_reg_rvalid            = rvalid_r;
   assign o_reg_hit               = hit_nxt;
   assign o_adc_error_summary     = adc_sum_r;
   assign o_ref_clk_present       = ref_ok_r;
   assign o_power_down_req        = proj_low_r;
   assign o_reset_cause           = cause;
   assign o_top_state             = state_r;
   assign o_phase_powerup         = phase_r[0];
   assign o_phase_display         = phase_r[1];
   assign o_phase_parking         = phase_r[2];
   assign o_state_unknown         = phase_r[3];
   assign o_mirror_offset_rail_up = offset_up_r;
   assign o_mirror_bias_rail_up   = bias_up_r;

endmodule

// >>> verif/sar_status_properties.sv
// Checker for the status bank: read port timing, field layout, sticky summary.
// Assumes binding to sar_status_top; it sees that module's ports only.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module sar_status_chk (
   // Clock and reset
   input wire                    i_clk_sys,
   input wire                    i_arst_n,
   input wire                    i_clk_en,
   // Register port
   input wire [`SAR_ADDR_W-1:0]  i_reg_addr,
   input wire                    i_reg_wr,
   input wire                    i_reg_rd,
   input wire [`SAR_DATA_W-1:0]  i_reg_wdata,
   input wire [`SAR_DATA_W-1:0]  o_reg_rdata,
   input wire                    o_reg_rvalid,
   input wire                    o_reg_hit,
   // Monitors and events
   input wire [`SAR_RATIO_W-1:0] i_clk_ratio,
   input wire                    i_adc_stop_bit_err,
   input wire                    i_adc_overlap_err,
   input wire                    i_adc_cmd_err,
   input wire                    i_adc_parity_err,
   input wire                    i_second_channel_underflow,
   input wire                    i_second_channel_sat,
   input wire                    i_first_channel_underflow,
   input wire                    i_first_channel_sat,
   // Status outputs
   input wire                    o_adc_error_summary,
   input wire                    o_ref_clk_present,
   input wire [`SAR_CAUSE_W-1:0] o_reset_cause,
   input wire [`SAR_STATE_W-1:0] o_top_state
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n || !i_clk_en);

   wire set_w = i_adc_stop_bit_err | i_adc_overlap_err | i_adc_cmd_err | i_adc_parity_err
              | i_second_channel_underflow | i_second_channel_sat | i_first_channel_underflow
              | i_first_channel_sat
              | (i_reg_wr && i_reg_addr == `SAR_ADDR_ADC_FLAGS && |i_reg_wdata[7:0]);
   wire rd_gen = i_reg_rd && i_reg_addr == `SAR_ADDR_GEN_STATUS;
   wire rd_adc = i_reg_rd && i_reg_addr == `SAR_ADDR_ADC_FLAGS;

   sequence s_flag_set;
      set_w;
   endsequence
   sequence s_sum_up;
      ##2 o_adc_error_summary;
   endsequence

   a_sum_on_set: assert property (s_flag_set |-> s_sum_up)
      else $error("summary did not follow a flag set");
   a_sum_source: assert property ($rose(o_adc_error_summary) |-> $past(set_w, 2))
      else $error("summary rose without a flag set");
   a_sum_sticky: assert property (o_adc_error_summary |=> o_adc_error_summary)
      else $error("summary dropped without reset");
   a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read got no valid pulse");
   a_gen_fields: assert property (rd_gen |=> o_reg_rdata[11:0] ==
         {4'h0, $past(o_reset_cause), $past(o_top_state)})
      else $error("general status fields wrong");
   a_adc_read_sum: assert property (rd_adc |=> o_reg_rdata[15:8] == 8'h00
         && o_adc_error_summary == |o_reg_rdata[7:0])
      else $error("flag read and summary disagree");
   a_unmapped_zero: assert property (i_reg_rd && !rd_gen && !rd_adc |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_ref_present: assert property ($past(i_arst_n, 2) |-> o_ref_clk_present ==
         ($past(i_clk_ratio, 2) >= `SAR_RATIO_MID_LO && $past(i_clk_ratio, 2) <= `SAR_RATIO_MID_HI))
      else $error("reference present flag wrong");
   a_cause_hold: assert property ($changed(o_reset_cause) |->
         o_top_state == `SAR_ST_OFF || $past(o_top_state) == `SAR_ST_OFF)
      else $error("reset cause changed outside off");
   a_hit_decode: assert property (o_reg_hit ==
         (i_reg_addr == `SAR_ADDR_GEN_STATUS || i_reg_addr == `SAR_ADDR_ADC_FLAGS))
      else $error("register hit decode wrong");
endmodule

bind sar_status_top sar_status_chk u_chk (.i_clk_sys, .i_arst_n, .i_clk_en, .i_reg_addr, .i_reg_wr, .i_reg_rd,
   .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .i_clk_ratio, .i_adc_stop_bit_err, .i_adc_overlap_err,
   .i_adc_cmd_err, .i_adc_parity_err, .i_second_channel_underflow, .i_second_channel_sat,
   .i_first_channel_underflow, .i_first_channel_sat, .o_adc_error_summary, .o_ref_clk_present,
   .o_reset_cause, .o_top_state);

// >>> verif/sar_host_model.sv
// Host model: issues register accesses as the serial control port would.
// Assumes a free-running i_clk_sys; one access at a time, changed on rising edges.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module sar_host_model (
   // Clock
   input  wire                   i_clk_sys,
   // Register port towards the bank
   output logic [`SAR_ADDR_W-1:0] o_reg_addr,
   output logic                  o_reg_wr,
   output logic                  o_reg_rd,
   output logic [`SAR_DATA_W-1:0] o_reg_wdata
);
   initial begin
      o_reg_addr  = 7'h7f;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_wdata = 16'hffff;
   end

   // Strobe for one edge, then scramble the idle bus so nothing leans on stale values
   task access(input logic wr, input logic rd, input logic [6:0] addr, input logic [15:0] data);
      begin
         @(posedge i_clk_sys);
         o_reg_addr  <= addr;
         o_reg_wr    <= wr;
         o_reg_rd    <= rd;
         o_reg_wdata <= data;
         @(posedge i_clk_sys);
         o_reg_wr    <= 1'b0;
         o_reg_rd    <= 1'b0;
         o_reg_addr  <= ~addr;
         o_reg_wdata <= ~data;
      end
   endtask
endmodule

// >>> verif/status_and_adc_error_registers_tb.sv
// Testbench for the status bank: host model reads, event pulses, queued expectations.
// Assumes sar_status_top, the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "sar_status_regs.vh"
module status_and_adc_error_registers_tb;
   logic        i_clk_sys  = 1'b0;
   logic        i_arst_n   = 1'b0;
   logic [3:0]  ratio      = 4'h0;
   logic [4:0]  state      = 5'h00;
   logic        proj       = 1'b1;
   logic        en         = 1'b1;
   logic [3:0]  cev        = 4'h0;
   logic [7:0]  ev         = 8'h00;
   wire  [6:0]  addr;
   wire         wr;
   wire         rd;
   wire  [15:0] wdata;
   wire  [15:0] rdata;
   wire         rvalid;
   wire         sum;
   wire         ref_ok;
   wire         pd;
   wire  [2:0]  cause;
   wire  [4:0]  top;
   wire  [5:0]  ph;
   logic [15:0] exp_q[$];
   logic [7:0]  exp_flags;
   logic [2:0]  exp_cause;
   logic [15:0] wv;
   logic [5:0]  exp_ph;
   integer      seed       = 32'he243;
   integer      n_mismatch = 0;
   integer      compares   = 0;
   integer      cycles     = 0;
   integer      i;
   logic [4:0]  codes [0:16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                                 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11};
   // Cause event per code: {over temp, sw cycle, wdog2, wdog1}
   logic [3:0]  cmap [0:5] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h8, 4'h4};

   always #12.5 i_clk_sys = ~i_clk_sys;

   sar_host_model u_host (.i_clk_sys(i_clk_sys), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_wdata(wdata));

   sar_status_top DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_en(en),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .o_reg_hit(), .i_clk_ratio(ratio), .i_top_state(state),
      .i_projector_on_input(proj), .i_wdog1_err(cev[0]), .i_wdog2_err(cev[1]), .i_over_temp(cev[3]),
      .i_sw_cycle(cev[2]), .i_adc_stop_bit_err(ev[7]), .i_adc_overlap_err(ev[6]), .i_adc_cmd_err(ev[5]),
      .i_adc_parity_err(ev[4]), .i_second_channel_underflow(ev[3]), .i_second_channel_sat(ev[2]),
      .i_first_channel_underflow(ev[1]), .i_first_channel_sat(ev[0]), .o_adc_error_summary(sum),
      .o_ref_clk_present(ref_ok), .o_power_down_req(pd), .o_reset_cause(cause), .o_top_state(top),
      .o_phase_powerup(ph[2]), .o_phase_display(ph[3]), .o_phase_parking(ph[4]), .o_state_unknown(ph[5]),
      .o_mirror_offset_rail_up(ph[0]), .o_mirror_bias_rail_up(ph[1]));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   task tick(input integer n);
      begin
         repeat (n) @(posedge i_clk_sys);
      end
   endtask

   task read_exp(input logic [6:0] a, input logic [15:0] e);
      begin
         exp_q.push_back(e);
         u_host.access(1'b0, 1'b1, a, 16'h0000);
         tick(2);
      end
   endtask

   task do_reset;
      begin
         i_arst_n <= 1'b0;
         tick(12);
         i_arst_n <= 1'b1;
         tick(2);
         exp_cause = 3'h0;
         exp_flags = 8'h00;
      end
   endtask

   function logic [15:0] gen_exp;
      gen_exp = {ratio, 4'h0, exp_cause, state};
   endfunction

   // Read result monitor and hang guard
   always @(posedge i_clk_sys) begin
      cycles = cycles + 1;
      if (rvalid === 1'b1)
         check(rdata, exp_q.pop_front(), "read data");
      if (cycles == 5000) begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
   end

   initial begin
      do_reset;
      read_exp(`SAR_ADDR_GEN_STATUS, 16'h0000);
      read_exp(`SAR_ADDR_ADC_FLAGS, 16'h0000);
      check({15'h0, sum}, 16'h0000, "summary");
      u_host.access(1'b1, 1'b0, `SAR_ADDR_GEN_STATUS, 16'hffff);
      u_host.access(1'b1, 1'b0, 7'h33, 16'hffff);
      read_exp(`SAR_ADDR_GEN_STATUS, 16'h0000);
      read_exp(7'h33, 16'h0000);
      // Frozen clock enable must not take an event
      en <= 1'b0;
      ev <= 8'h80;
      tick(3);
      ev <= 8'h00;
      tick(1);
      en <= 1'b1;
      tick(2);
      read_exp(`SAR_ADDR_ADC_FLAGS, 16'h0000);
      $display("test reset, read-only and freeze done");
      for (i = 0; i < 17; i++) begin
         @(posedge i_clk_sys);
         state <= codes[i];
         ratio <= (i < 3) ? 4'(7 + i) : 4'($random(seed));
         tick(3);
         check({15'h0, ref_ok}, {15'h0, ratio >= 4'h7 && ratio <= 4'h9}, "ref present");
         check({11'h0, top}, {11'h0, state}, "top state");
         exp_ph = {1'b0, i > 12, i > 8 && i < 13, i < 9, i > 9 && i < 14, i > 8 && i < 15};
         check({10'h0, ph}, {10'h0, exp_ph}, "phase");
         read_exp(`SAR_ADDR_GEN_STATUS, gen_exp());
      end
      state <= 5'h0b;
      tick(3);
      check({10'h0, ph}, 16'h0020, "phase unknown");
      $display("test state codes done");
      for (i = 1; i < 6; i++) begin
         @(posedge i_clk_sys);
         state <= `SAR_ST_STANDBY;
         tick(3);
         proj <= (i != 1);
         cev  <= cmap[i];
         tick(2);
         check({15'h0, pd}, {15'h0, i == 1}, "power down request");
         proj <= 1'b1;
         cev  <= 4'h0;
         tick(3);
         state <= `SAR_ST_OFF;
         tick(5);
         exp_cause = 3'(i);
         check({13'h0, cause}, {13'h0, exp_cause}, "reset cause");
         read_exp(`SAR_ADDR_GEN_STATUS, gen_exp());
      end
      state <= `SAR_ST_DISPLAY_ON;
      tick(4);
      read_exp(`SAR_ADDR_GEN_STATUS, gen_exp());
      $display("test reset causes done");
      for (i = 0; i < 8; i++) begin
         ev <= 8'h01 << i;
         tick(1);
         ev <= 8'h00;
         tick(3);
         exp_flags = exp_flags | (8'h01 << i);
         read_exp(`SAR_ADDR_ADC_FLAGS, {8'h00, exp_flags});
         check({15'h0, sum}, 16'h0001, "summary");
      end
      $display("test adc flags done");
      do_reset;
      read_exp(`SAR_ADDR_ADC_FLAGS, 16'h0000);
      read_exp(`SAR_ADDR_GEN_STATUS, gen_exp());
      u_host.access(1'b1, 1'b0, `SAR_ADDR_ADC_FLAGS, 16'hff00);
      read_exp(`SAR_ADDR_ADC_FLAGS, 16'h0000);
      u_host.access(1'b1, 1'b0, `SAR_ADDR_ADC_FLAGS, 16'h0001);
      u_host.access(1'b1, 1'b0, `SAR_ADDR_ADC_FLAGS, 16'h0000);
      exp_flags = 8'h01;
      read_exp(`SAR_ADDR_ADC_FLAGS, 16'h0001);
      for (i = 0; i < 4; i++) begin
         wv = 16'($random(seed));
         u_host.access(1'b1, 1'b0, `SAR_ADDR_ADC_FLAGS, wv);
         exp_flags = exp_flags | wv[7:0];
         read_exp(`SAR_ADDR_ADC_FLAGS, {8'h00, exp_flags});
      end
      $display("test flag writes done");
      tick(4);
      check(16'(exp_q.size()), 16'h0000, "pending reads");
      summarize;
   end
endmodule
